/* File: hw/lts_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register port with a 5-bit address space or wider
`ifndef LTS_DEFINES_SVH
`define LTS_DEFINES_SVH
`define LTS_OFS_CAL 8'h19
`define LTS_OFS_DCT 8'h1A
`define LTS_OFS_RSV 8'h1B
`define LTS_OFS_LCS 8'h1C
`define LTS_OFS_LVS 8'h1D
`define LTS_BIT_CAL_BUSY 7
`define LTS_BIT_CAL_MAN 6
`define LTS_BIT_CAL_DIS 5
`define LTS_BIT_CAL_RSV 4
`define LTS_BIT_CURRENT_LIMIT_EN 1
`define LTS_BIT_DCR 0
`define LTS_RST_CAL 8'h00
`define LTS_RST_DCT 8'h00
`define LTS_RST_MON 8'h00
`define LTS_CAL_TIME_US 100
`define LTS_CLK_MHZ 10
`define LTS_CAL_CYCLES ((`LTS_CAL_TIME_US) * (`LTS_CLK_MHZ))
`endif

/* File: hw/lts_pkg.sv */
// types shared by the termination and status register bank
// assumes nothing of its surroundings
package lts_pkg;
  typedef enum logic [1:0] {
    LTS_CAL_IDLE = 2'b01,
    LTS_CAL_RUN = 2'b10
  } lts_cal_e;
  typedef logic [7:0] lts_byte_t;
endpackage : lts_pkg

/* File: hw/lts_cal_if.sv */
// interface between register bank and calibration sequencer
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface lts_cal_if;
  logic start;
  logic disable_cal;
  logic busy;
  logic [3:0] value;
  modport bank (output start, output disable_cal, input busy, input value);
  modport seq (input start, input disable_cal, output busy, output value);
endinterface : lts_cal_if
`default_nettype wire

/* File: hw/lts_cal_seq.sv */
// resistor calibration sequencer: runs after reset and on manual start
// assumes sys_clk_i at 10 MHz
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.svh"
module lts_cal_seq
  import lts_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  lts_cal_if.seq cal
);
  localparam logic [11:0] CAL_LAST = 12'(`LTS_CAL_CYCLES - 1);
  lts_cal_e state_reg;
  lts_cal_e state_next;
  logic [11:0] cnt_reg;
  logic auto_pend_reg;
  logic [3:0] val_reg;
  wire want_run = cal.start | (auto_pend_reg & ~cal.disable_cal);
  wire done = (cnt_reg == CAL_LAST);
  // ----------------------------------------------------------------
  // state step
  // ----------------------------------------------------------------
  // disable blocks calibration
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LTS_CAL_IDLE: if (want_run && !cal.disable_cal) begin
        state_next = LTS_CAL_RUN;
      end
      LTS_CAL_RUN: if (done) begin
        state_next = LTS_CAL_IDLE;
      end
      default: state_next = LTS_CAL_IDLE;
    endcase
  end
  // state, counter and result registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= LTS_CAL_IDLE;
      cnt_reg <= 12'h000;
      auto_pend_reg <= 1'b1;
      val_reg <= 4'h8;
    end else begin
      state_reg <= state_next;
      if (state_reg == LTS_CAL_RUN) begin
        auto_pend_reg <= 1'b0;
        cnt_reg <= done ? 12'h000 : cnt_reg + 12'h001;
        if (done) begin
          val_reg <= val_reg + 4'h1; // trimmed result stands in here
        end
      end
    end
  end
  assign cal.busy = (state_reg == LTS_CAL_RUN);
  assign cal.value = val_reg;
  chk_cal_busy_len: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(cal.busy) |-> cal.busy [*8]) else $error("calibration ended early");
  chk_cal_disable: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!cal.busy && cal.disable_cal) |=> !cal.busy)
    else $error("calibration ran while disabled");
endmodule : lts_cal_seq
`default_nettype wire

/* File: hw/lts_regs.sv */
// line termination and status register bank
// assumes a synchronous 8-bit register port and monitor inputs from the
// line-side converters, all on sys_clk_i
//
// Behaviour
// - calibration busy bit reads 1 during calibration, else 0; read only
// - writing 1 to manual bit starts a resistor calibration
// - disable bit at 1 suppresses internal resistor calibration
// - bit 4 of calibration register accepts any value, no effect
// - voltage field picks 3.1, 3.2, 3.35 or 3.5 V pin level
// - minimum loop current field picks 10, 12, 14 or 16 mA
// - current limit bit caps loop current at 60 mA
// - impedance bit selects 50 ohm at 0, 800 ohm at 1
// - loop current register reports unsigned count of 1.1 mA
// - loop current zero means too little current for operation
// - line voltage register reports signed volts, two's complement
// - line voltage keeps updating on-hook and off-hook
// - line voltage top bit is polarity, change means reversal
// - line voltage zero means no line attached
// - loop current register resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.svh"
module lts_regs
  import lts_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] loop_current_sample_i,
  input wire logic [7:0] line_voltage_sample_i,
  input wire logic sample_valid_i,
  output logic [1:0] tip_ring_voltage_sel_o,
  output logic [1:0] min_loop_current_sel_o,
  output logic current_limit_en_o,
  output logic dc_impedance_sel_o,
  output logic cal_in_progress_o,
  output logic low_loop_current_o,
  output logic no_line_o,
  output logic polarity_o,
  output logic polarity_reversal_o
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit
  wire wr_cal = reg_wr_i & hit(reg_addr_i, `LTS_OFS_CAL);
  wire wr_dct = reg_wr_i & hit(reg_addr_i, `LTS_OFS_DCT);
  lts_cal_if cal_bus ();
  lts_byte_t cal_ctl_reg;
  lts_byte_t dct_reg;
  lts_byte_t lcs_reg;
  lts_byte_t lvs_reg;
  lts_byte_t rdata_next;
  logic pol_prev_reg;
  logic rev_reg;
  logic seen_reg;
  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  lts_cal_seq u_cal (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cal(cal_bus.seq)
  );
  // manual bit starts run; disable in same write wins
  assign cal_bus.start = wr_cal & reg_wdata_i[`LTS_BIT_CAL_MAN] &
                         ~reg_wdata_i[`LTS_BIT_CAL_DIS];
  assign cal_bus.disable_cal = cal_ctl_reg[`LTS_BIT_CAL_DIS];
  // control registers; calibration value bits are owned by the sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_ctl_reg <= `LTS_RST_CAL;
      dct_reg <= `LTS_RST_DCT;
    end else begin
      if (wr_cal) begin
        cal_ctl_reg <= {1'b0, reg_wdata_i[6:4], 4'h0};
      end
      if (wr_dct) begin
        dct_reg <= {reg_wdata_i[7:4], 2'b00, reg_wdata_i[1:0]};
      end
    end
  end
  // ----------------------------------------------------------------
  // monitor registers
  // ----------------------------------------------------------------
  // sample in any hook state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lcs_reg <= `LTS_RST_MON;
      lvs_reg <= `LTS_RST_MON;
      pol_prev_reg <= 1'b0;
      rev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      rev_reg <= 1'b0;
      if (sample_valid_i) begin
        lcs_reg <= loop_current_sample_i;
        lvs_reg <= line_voltage_sample_i;
        pol_prev_reg <= line_voltage_sample_i[7];
        seen_reg <= 1'b1;
        rev_reg <= seen_reg & (line_voltage_sample_i[7] ^ pol_prev_reg);
      end
    end
  end
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // busy bit in read data
  always_comb begin
    case (reg_addr_i)
      `LTS_OFS_CAL: rdata_next = {cal_bus.busy, cal_ctl_reg[6:4],
                                  cal_bus.value};
      `LTS_OFS_DCT: rdata_next = dct_reg;
      `LTS_OFS_LCS: rdata_next = lcs_reg;
      `LTS_OFS_LVS: rdata_next = lvs_reg;
      default: rdata_next = 8'h00;
    endcase
  end
  // registered read data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end
  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  // pin voltage select
  assign tip_ring_voltage_sel_o = dct_reg[7:6];
  assign min_loop_current_sel_o = dct_reg[5:4];
  assign current_limit_en_o = dct_reg[`LTS_BIT_CURRENT_LIMIT_EN];
  assign dc_impedance_sel_o = dct_reg[`LTS_BIT_DCR];
  assign cal_in_progress_o = cal_bus.busy;
  assign low_loop_current_o = (lcs_reg == 8'h00);
  assign no_line_o = (lvs_reg == 8'h00);
  assign polarity_o = lvs_reg[7];
  assign polarity_reversal_o = rev_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // calibration length is counted here, a long repetition is too slow
  localparam logic [11:0] CAL_LEN = 12'(`LTS_CAL_CYCLES);
  logic [11:0] busy_len_reg;
  // busy cycles of the current run, cleared while idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_len_reg <= 12'h000;
    end else if (cal_bus.busy) begin
      busy_len_reg <= busy_len_reg + 12'h001;
    end else begin
      busy_len_reg <= 12'h000;
    end
  end
  chk_dct_write_mask: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_dct |=> (dct_reg[3:2] == 2'b00 &&
    dct_reg[1:0] == $past(reg_wdata_i[1:0])))
    else $error("termination write wrong");
  chk_manual_start: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (cal_bus.start && !cal_bus.disable_cal && !cal_bus.busy) |=> cal_bus.busy)
    else $error("manual start ignored");
  chk_lcs_follow: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_valid_i |=> lcs_reg == $past(loop_current_sample_i))
    else $error("loop current not updated");
  chk_lvs_follow: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_valid_i |=> lvs_reg == $past(line_voltage_sample_i))
    else $error("line voltage not updated");
  chk_mon_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !sample_valid_i |=> $stable(lcs_reg) && $stable(lvs_reg))
    else $error("monitor changed without sample");
  chk_pol_reverse: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (seen_reg && sample_valid_i && line_voltage_sample_i[7] != lvs_reg[7])
    |=> polarity_reversal_o) else $error("reversal missed");
  chk_busy_read: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `LTS_OFS_CAL) |=>
    reg_rdata_o[7] == $past(cal_bus.busy))
    else $error("busy bit read wrong");
  chk_no_line: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (lvs_reg == 8'h00) |-> no_line_o)
    else $error("no line flag wrong");
  chk_cal_length: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(cal_bus.busy) |-> busy_len_reg == CAL_LEN)
    else $error("calibration length wrong");
  // busy and value bits not stored
  chk_cal_ro_bits: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_cal |=> cal_ctl_reg[7] == 1'b0 && cal_ctl_reg[3:0] == 4'h0)
    else $error("read-only calibration bits stored");
  chk_cal_store: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_cal |=> cal_ctl_reg[6:4] == $past(reg_wdata_i[6:4]))
    else $error("calibration control not stored");
  // disable in a start write wins
  chk_start_gated: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_cal && reg_wdata_i[`LTS_BIT_CAL_DIS] && !cal_bus.busy) |=>
    !cal_bus.busy) else $error("calibration started while disabled");
  chk_trv_field: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_dct |=> tip_ring_voltage_sel_o == $past(reg_wdata_i[7:6]))
    else $error("voltage select wrong");
  chk_mlc_field: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_dct |=> min_loop_current_sel_o == $past(reg_wdata_i[5:4]))
    else $error("minimum current select wrong");
  chk_current_limit_en_field: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_dct |=> current_limit_en_o == $past(reg_wdata_i[`LTS_BIT_CURRENT_LIMIT_EN]))
    else $error("current limit enable wrong");
  chk_dcr_field: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_dct |=> dc_impedance_sel_o == $past(reg_wdata_i[`LTS_BIT_DCR]))
    else $error("impedance select wrong");
  chk_dct_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !wr_dct |=> $stable(dct_reg))
    else $error("termination changed without write");
  chk_low_current: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (sample_valid_i && loop_current_sample_i == 8'h00) |=> low_loop_current_o)
    else $error("low current flag missed");
  chk_current_ok: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (sample_valid_i && loop_current_sample_i != 8'h00) |=>
    !low_loop_current_o) else $error("low current flag false");
  chk_pol_follow: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_valid_i |=> polarity_o == $past(line_voltage_sample_i[7]))
    else $error("polarity output wrong");
  chk_rev_cause: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    polarity_reversal_o |-> $past(sample_valid_i))
    else $error("reversal without sample");
  chk_lcs_read: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `LTS_OFS_LCS) |=> reg_rdata_o == $past(lcs_reg))
    else $error("loop current read wrong");
  chk_lvs_read: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `LTS_OFS_LVS) |=> reg_rdata_o == $past(lvs_reg))
    else $error("line voltage read wrong");
  chk_lcs_reset: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !seen_reg |-> lcs_reg == 8'h00)
    else $error("loop current not zero after reset");
  chk_line_zero: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (sample_valid_i && line_voltage_sample_i == 8'h00) |=> no_line_o)
    else $error("no line flag missed");
  chk_rdata_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  chk_unmapped_read: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && (reg_addr_i < `LTS_OFS_CAL || reg_addr_i > `LTS_OFS_LVS))
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule : lts_regs
`default_nettype wire

/* File: tb/tb.sv */
// tb: self-checking bench for the termination and status register bank
// assumes lts_regs alone on a 10 MHz clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.svh"
module tb;
  import lts_pkg::*;
  logic clk, rst, wr, rd, sv, rd_d, hp, pv;
  logic [7:0] adr, wd, lc, lv, rdat, s, d, last, lcv, lvv;
  logic [1:0] trv, mlc;
  logic current_limit_en, dc_impedance_sel, busy, low, nol, pol, rev;
  logic [15:0] q[$];
  logic [15:0] nq;
  int fails, n_checks, revs, exp_revs, bc, n;

  lts_regs lts_regs_i (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(adr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .loop_current_sample_i(lc), .line_voltage_sample_i(lv),
    .sample_valid_i(sv), .tip_ring_voltage_sel_o(trv),
    .min_loop_current_sel_o(mlc), .current_limit_en_o(current_limit_en),
    .dc_impedance_sel_o(dc_impedance_sel), .cal_in_progress_o(busy),
    .low_loop_current_o(low), .no_line_o(nol), .polarity_o(pol),
    .polarity_reversal_o(rev));

  // ----------------------------------------
  // clock, checking helpers and closing
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nx
  task automatic chk(input logic [7:0] g, e, m);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chkn(input int g, e);
    n_checks++;
    if (g != e) begin
      fails++;
      $display("mismatch t=%0t count %0d exp %0d", $time, g, e);
    end
  endtask : chkn
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ----------------------------------------
  // bus drivers; reads note the expectation
  // ----------------------------------------
  task automatic wr8(input logic [7:0] a, v);
    @(posedge clk);
    adr <= a; wd <= v; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr8
  task automatic rd8(input logic [7:0] a, e, m);
    @(posedge clk);
    adr <= a; rd <= 1;
    q.push_back({m, e});
    @(posedge clk);
    rd <= 0;
  endtask : rd8
  // one manual start; u is the upper nibble written
  task automatic calrun(input logic [3:0] u, input logic en);
    rd8(`LTS_OFS_CAL, 8'h00, 8'hE0);
    repeat (2) @(posedge clk);
    d = {u, last[3:0]};
    bc = 0;
    wr8(`LTS_OFS_CAL, d);
    wr8(`LTS_OFS_CAL, d & 8'hBF);
    rd8(`LTS_OFS_CAL, {en, 1'b0, d[5:4], 4'h0}, 8'hF0);
    n = 0;
    while (busy !== 1'b0 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chkn(bc, en ? `LTS_CAL_CYCLES : 0);
  endtask : calrun

  // ----------------------------------------
  // output watcher and counters
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_d <= 0;
    end else begin
      if (rd_d) begin
        nq = q.pop_front();
        chk(rdat, nq[7:0], nq[15:8]);
        last <= rdat;
      end
      rd_d <= rd;
    end
  end
  always @(posedge clk) begin
    if (busy === 1'b1) bc++;
    if (rev === 1'b1) revs++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1; wr = 0; rd = 0; sv = 0; adr = 0; wd = 0;
    lc = 0; lv = 0; s = 8'h54; hp = 0; pv = 0; last = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    // busy rises at the first edge after release
    repeat (2) @(negedge clk);
    chk({7'h00, busy}, 8'h01, 8'hFF);
    rd8(`LTS_OFS_LCS, 8'h00, 8'hFF);
    rd8(`LTS_OFS_CAL, 8'h80, 8'hF0);
    rd8(8'h05, 8'h00, 8'hFF);
    rd8(`LTS_OFS_RSV, 8'h00, 8'hFF);
    // let the calibration that follows reset run out
    repeat (`LTS_CAL_CYCLES) @(posedge clk);
    chkn(bc, `LTS_CAL_CYCLES);
    calrun(4'h4, 1);
    calrun(4'h5, 1);
    calrun(4'h6, 0);
    for (int i = 0; i < 16; i++) begin
      s = nx(s);
      d = {i[3:0], 2'b00, s[1:0]};
      wr8(`LTS_OFS_DCT, d);
      @(negedge clk);
      chk({trv, mlc, 2'b00, current_limit_en, dc_impedance_sel}, d, 8'hFF);
      rd8(`LTS_OFS_DCT, d, 8'hFF);
    end
    for (int i = 0; i < 12; i++) begin
      s = nx(s);
      lcv = (i == 4) ? 8'h00 : s;
      s = nx(s);
      lvv = (i == 5) ? 8'h00 : s;
      if (hp && lvv[7] != pv) exp_revs++;
      hp = 1;
      pv = lvv[7];
      @(posedge clk);
      lc <= lcv; lv <= lvv; sv <= 1;
      @(posedge clk);
      sv <= 0;
      @(negedge clk);
      chk({low, nol, pol}, {lcv == 0, lvv == 0, lvv[7]}, 8'h07);
      rd8(`LTS_OFS_LCS, lcv, 8'hFF);
      rd8(`LTS_OFS_LVS, lvv, 8'hFF);
      wr8(`LTS_OFS_LCS, ~lcv);
      wr8(`LTS_OFS_LVS, ~lvv);
      rd8(`LTS_OFS_LCS, lcv, 8'hFF);
      rd8(`LTS_OFS_LVS, lvv, 8'hFF);
    end
    repeat (3) @(posedge clk);
    chkn(revs, exp_revs);
    results();
  end
endmodule : tb
`default_nettype wire
